/* shared/src_pkg.sv */
// Package for the stepper run controller: offsets, fields, types
package src_pkg;
  localparam logic [7:0] ADDR_RAMP_SETUP = 8'h24;
  localparam logic [7:0] ADDR_REV_WAIT = 8'h25;
  localparam logic [7:0] ADDR_CMD = 8'h26;
  localparam logic [7:0] ADDR_PARAM_LO = 8'h0E;
  localparam logic [7:0] ADDR_CW_STEP_L = 8'h1A;
  localparam logic [7:0] ADDR_CW_TURN_L = 8'h1E;
  localparam logic [7:0] ADDR_CCW_STEP_L = 8'h1C;
  localparam logic [7:0] ADDR_CCW_TURN_L = 8'h20;
  localparam int CMD_START_BIT = 7;
  localparam int CMD_HARD_BIT = 5;
  localparam int CMD_CONT_BIT = 4;
  localparam int RAMP_UP_BIT = 5;
  localparam int RAMP_DOWN_BIT = 4;
  localparam logic [7:0] CMD_WRITE_MASK = 8'hBF;
  localparam logic [7:0] RAMP_WRITE_MASK = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] COIL_CW_FIRST = 2'h0;
  localparam logic [1:0] COIL_CCW_FIRST = 2'h3;
  localparam longint CLK_HZ = 125000000;
  localparam longint TICK_S = 1;
  localparam longint TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [1:0] TGT_STEPS = 2'h0;
  localparam logic [1:0] TGT_TURNS = 2'h1;
  localparam logic [1:0] DIR_CW = 2'h0;
  localparam logic [1:0] DIR_CCW = 2'h1;
  localparam logic [1:0] DIR_CW_CCW = 2'h2;
  localparam logic [1:0] DIR_CCW_CW = 2'h3;

  typedef struct packed {
    logic start;
    logic rsvd;
    logic hard;
    logic cont;
    logic [1:0] target;
    logic [1:0] dir;
  } src_cmd_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } src_wr_t;

  typedef struct packed {
    logic [15:0] cw_steps;
    logic [15:0] cw_turns;
    logic [15:0] ccw_steps;
    logic [15:0] ccw_turns;
  } src_counts_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RAMP_UP, ST_CRUISE, ST_RAMP_DOWN, ST_REV_WAIT
  } src_state_t;
endpackage

/* logic/src_sec_tick.sv */
// One-second tick divider and reversal wait counter
`timescale 1ns/1ns
`default_nettype none
module src_sec_tick #(
  parameter longint TICK_CYCLES = src_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] seconds,
  output logic done
);
  import src_pkg::*;
  logic [31:0] div_q;
  logic [7:0] left_q;
  logic busy_q;
  wire logic tick = (div_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
    end else if (load || tick) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 8'h00;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        left_q <= seconds;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (left_q == 8'h00) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else if (tick) begin
          left_q <= left_q - 8'h01;
        end
      end
    end
  end

  property p_zero_wait;
    @(posedge clk) disable iff (!rst_n)
      (load && seconds == 8'h00) |-> ##2 done;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("zero wait late");
endmodule
`default_nettype wire

/* logic/src_coil_track.sv */
// Coil position tracker for run resume
`timescale 1ns/1ns
`default_nettype none
module src_coil_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic ccw,
  input wire logic advance,
  output logic [1:0] coil,
  output logic ref_step
);
  import src_pkg::*;
  logic seen_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      coil <= COIL_CW_FIRST;
      ref_step <= 1'b0;
    end else begin
      if (start) begin
        seen_q <= 1'b1;
        ref_step <= !seen_q;
        if (!seen_q) begin
          coil <= ccw ? COIL_CCW_FIRST : COIL_CW_FIRST;
        end
      end else if (advance) begin
        ref_step <= 1'b0;
        coil <= ccw ? coil - 2'h1 : coil + 2'h1;
      end
    end
  end

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
      (start && seen_q) |=> (coil == $past(coil));
  endproperty
  a_resume: assert property (p_resume) else $error("coil not resumed");
endmodule
`default_nettype wire

/* logic/src_run_ctrl.sv */
// Stepper run controller top: registers, run machine, stop handling
`timescale 1ns/1ns
`default_nettype none
module src_run_ctrl #(
  parameter longint TICK_CYCLES = src_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire src_pkg::src_wr_t reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire src_pkg::src_counts_t counts,
  input wire logic step_pulse,
  input wire logic turn_pulse,
  input wire logic ramp_up_done,
  input wire logic ramp_down_done,
  input wire logic irq_stop,
  input wire logic irq_reverse,
  output logic [7:0] reg_rd_data,
  output logic run_active,
  output logic run_ccw,
  output logic ramping_up,
  output logic ramping_down,
  output logic params_locked,
  output logic [1:0] coil_index,
  output logic ref_step_out
);
  import src_pkg::*;

  src_cmd_t cmd_q;
  logic [7:0] rev_wait_q;
  logic [7:0] ramp_q;
  src_state_t state_q;
  logic ccw_q;
  logic second_leg_q;
  logic [15:0] step_left_q;
  logic [15:0] turn_left_q;
  logic irq_stop_q;
  logic irq_rev_q;
  logic wait_load_q;
  logic rev_is_irq_q;
  logic wait_done;
  logic [1:0] coil;
  logic ref_step;

  function automatic logic counts_ok(input logic [1:0] tgt,
                                     input logic [15:0] s,
                                     input logic [15:0] r);
    if (tgt == TGT_STEPS) begin
      counts_ok = (s != 16'h0000);
    end else if (tgt == TGT_TURNS) begin
      counts_ok = (r != 16'h0000);
    end else begin
      counts_ok = (s != 16'h0000) || (r != 16'h0000);
    end
  endfunction

  function automatic logic job_ok(input src_cmd_t c, input src_counts_t n);
    logic cw_ok;
    logic ccw_ok;
    cw_ok = counts_ok(c.target, n.cw_steps, n.cw_turns);
    ccw_ok = counts_ok(c.target, n.ccw_steps, n.ccw_turns);
    unique case (c.dir)
      DIR_CW: job_ok = cw_ok;
      DIR_CCW: job_ok = ccw_ok;
      default: job_ok = cw_ok && ccw_ok;
    endcase
  endfunction

  wire logic running = (state_q != ST_IDLE);
  wire logic cmd_wr = reg_wr.wr && (reg_wr.addr == ADDR_CMD);
  wire logic start_req = cmd_wr && reg_wr.data[CMD_START_BIT] && !running;
  wire logic stop_req = cmd_wr && !reg_wr.data[CMD_START_BIT] && running;
  wire src_cmd_t new_cmd = src_cmd_t'(reg_wr.data & CMD_WRITE_MASK);
  wire logic start_ok = start_req && job_ok(new_cmd, counts);
  wire logic start_ccw = (new_cmd.dir == DIR_CCW) ||
                         (new_cmd.dir == DIR_CCW_CW);
  wire logic reversal_dir = cmd_q.dir[1];
  wire logic in_ramp = (state_q == ST_RAMP_UP) || (state_q == ST_RAMP_DOWN);
  wire logic cruise = (state_q == ST_CRUISE);
  wire logic use_steps = (cmd_q.target != TGT_TURNS);
  wire logic use_turns = (cmd_q.target != TGT_STEPS);
  wire logic step_cnt = step_pulse && !ref_step &&
                        (state_q != ST_REV_WAIT);
  wire logic steps_zero = !use_steps || (step_left_q == 16'h0000);
  wire logic turns_zero = !use_turns || (turn_left_q == 16'h0000);
  wire logic leg_end = running && (state_q != ST_REV_WAIT) &&
                       steps_zero && turns_zero;
  wire logic leg_next_ccw = !ccw_q;

  function automatic logic [15:0] pick(input logic ccw,
                                       input logic [15:0] a,
                                       input logic [15:0] b);
    pick = ccw ? b : a;
  endfunction

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_wait_q <= REG_RESET;
      ramp_q <= REG_RESET;
    end else if (reg_wr.wr && !running) begin
      if (reg_wr.addr == ADDR_REV_WAIT) begin
        rev_wait_q <= reg_wr.data;
      end
      if (reg_wr.addr == ADDR_RAMP_SETUP) begin
        ramp_q <= reg_wr.data & RAMP_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= src_cmd_t'(REG_RESET);
    end else if (cmd_wr && !running) begin
      cmd_q <= new_cmd;
      cmd_q.start <= start_ok;
    end else if (!running) begin
      cmd_q.start <= 1'b0;
    end else begin
      cmd_q.start <= 1'b1;
    end
  end

  // Interrupts latched during ramps and reversal wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stop_q <= 1'b0;
      irq_rev_q <= 1'b0;
    end else if (!running) begin
      irq_stop_q <= 1'b0;
      irq_rev_q <= 1'b0;
    end else if (cruise) begin
      irq_stop_q <= 1'b0;
      irq_rev_q <= 1'b0;
    end else begin
      irq_stop_q <= irq_stop_q || irq_stop;
      irq_rev_q <= irq_rev_q || irq_reverse;
    end
  end

  wire logic act_stop = cruise && (irq_stop || irq_stop_q);
  wire logic act_rev = cruise && (irq_reverse || irq_rev_q);

  // Run state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wait_load_q <= 1'b0;
      rev_is_irq_q <= 1'b0;
    end else begin
      wait_load_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ramp_q[RAMP_UP_BIT] ? ST_RAMP_UP : ST_CRUISE;
          end
        end
        ST_RAMP_UP: begin
          if (stop_req) begin
            if (cmd_q.hard) begin
              state_q <= ST_IDLE;
            end else if (ramp_q[RAMP_DOWN_BIT]) begin
              state_q <= ST_RAMP_DOWN;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (leg_end) begin
            state_q <= ST_IDLE;
          end else if (ramp_up_done) begin
            state_q <= ST_CRUISE;
          end
        end
        ST_CRUISE: begin
          if (stop_req) begin
            state_q <= (ramp_q[RAMP_DOWN_BIT] && !cmd_q.hard) ?
                       ST_RAMP_DOWN : ST_IDLE;
          end else if (act_stop) begin
            state_q <= ramp_q[RAMP_DOWN_BIT] ? ST_RAMP_DOWN : ST_IDLE;
          end else if (act_rev || (leg_end && (reversal_dir &&
                       (!second_leg_q || cmd_q.cont)))) begin
            state_q <= ST_REV_WAIT;
            wait_load_q <= 1'b1;
            rev_is_irq_q <= act_rev;
          end else if (leg_end && cmd_q.cont) begin
            state_q <= ST_CRUISE;
          end else if (leg_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RAMP_DOWN: begin
          if (stop_req && cmd_q.hard) begin
            state_q <= ST_IDLE;
          end else if (ramp_down_done || leg_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_REV_WAIT: begin
          if (stop_req) begin
            state_q <= ST_IDLE;
          end else if (wait_done) begin
            state_q <= ramp_q[RAMP_UP_BIT] ? ST_RAMP_UP : ST_CRUISE;
          end
        end
      endcase
    end
  end

  // Leg direction and counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ccw_q <= 1'b0;
      second_leg_q <= 1'b0;
      step_left_q <= 16'h0000;
      turn_left_q <= 16'h0000;
    end else if (start_ok) begin
      ccw_q <= start_ccw;
      second_leg_q <= 1'b0;
      step_left_q <= pick(start_ccw, counts.cw_steps, counts.ccw_steps);
      turn_left_q <= pick(start_ccw, counts.cw_turns, counts.ccw_turns);
    end else if (state_q == ST_REV_WAIT && wait_done) begin
      ccw_q <= leg_next_ccw;
      second_leg_q <= rev_is_irq_q ? second_leg_q : !second_leg_q;
      step_left_q <= pick(leg_next_ccw, counts.cw_steps, counts.ccw_steps);
      turn_left_q <= pick(leg_next_ccw, counts.cw_turns, counts.ccw_turns);
    end else if (cruise && leg_end && cmd_q.cont && !reversal_dir) begin
      step_left_q <= pick(ccw_q, counts.cw_steps, counts.ccw_steps);
      turn_left_q <= pick(ccw_q, counts.cw_turns, counts.ccw_turns);
    end else begin
      if (step_cnt && use_steps && step_left_q != 16'h0000) begin
        step_left_q <= step_left_q - 16'h0001;
      end else if (turn_pulse && turns_zero == 1'b0 && steps_zero) begin
        turn_left_q <= turn_left_q - 16'h0001;
      end
    end
  end

  // Read mux and status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
      run_active <= 1'b0;
      run_ccw <= 1'b0;
      ramping_up <= 1'b0;
      ramping_down <= 1'b0;
      params_locked <= 1'b0;
    end else begin
      unique case (reg_rd_addr)
        ADDR_CMD: reg_rd_data <= cmd_q;
        ADDR_REV_WAIT: reg_rd_data <= rev_wait_q;
        ADDR_RAMP_SETUP: reg_rd_data <= ramp_q;
        default: reg_rd_data <= 8'h00;
      endcase
      run_active <= running && (state_q != ST_REV_WAIT);
      run_ccw <= ccw_q;
      ramping_up <= (state_q == ST_RAMP_UP);
      ramping_down <= (state_q == ST_RAMP_DOWN);
      params_locked <= running;
    end
  end

  assign coil_index = coil;
  assign ref_step_out = ref_step;

  src_sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .load(wait_load_q),
    .seconds(rev_wait_q),
    .done(wait_done)
  );

  src_coil_track u_coil (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_ok),
    .ccw(start_req ? start_ccw : ccw_q),
    .advance(step_pulse && running),
    .coil(coil),
    .ref_step(ref_step)
  );

  property p_restart_ignored;
    @(posedge clk) disable iff (!rst_n)
      (cmd_wr && running) |=> (cmd_q[6:0] == $past(cmd_q[6:0]));
  endproperty
  a_restart_ignored: assert property (p_restart_ignored)
    else $error("bits changed");

  property p_start_bit;
    @(posedge clk) disable iff (!rst_n)
      running |=> (cmd_q.start == $past(running));
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit wrong");

  property p_hard_rampup;
    @(posedge clk) disable iff (!rst_n)
      (state_q == ST_RAMP_UP && stop_req && cmd_q.hard) |=> state_q == ST_IDLE;
  endproperty
  a_hard_rampup: assert property (p_hard_rampup)
    else $error("no hard stop");

  property p_soft_rampup;
    @(posedge clk) disable iff (!rst_n)
      (state_q == ST_RAMP_UP && stop_req && !cmd_q.hard &&
       ramp_q[RAMP_DOWN_BIT]) |=> state_q == ST_RAMP_DOWN;
  endproperty
  a_soft_rampup: assert property (p_soft_rampup)
    else $error("no ramp down");

  property p_rampdown_soft;
    @(posedge clk) disable iff (!rst_n)
      (state_q == ST_RAMP_DOWN && stop_req && !cmd_q.hard &&
       !ramp_down_done && !leg_end) |=> state_q == ST_RAMP_DOWN;
  endproperty
  a_rampdown_soft: assert property (p_rampdown_soft)
    else $error("ramp aborted");

  property p_irq_blocked;
    @(posedge clk) disable iff (!rst_n)
      (state_q == ST_RAMP_UP && irq_stop && !stop_req && !leg_end)
        |=> state_q != ST_IDLE;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("irq in ramp");

  property p_irq_latched;
    @(posedge clk) disable iff (!rst_n)
      (in_ramp && irq_stop) |=> (irq_stop_q || !in_ramp);
  endproperty
  a_irq_latched: assert property (p_irq_latched)
    else $error("irq lost");

  property p_bad_job;
    @(posedge clk) disable iff (!rst_n)
      (start_req && !job_ok(new_cmd, counts)) |=> state_q == ST_IDLE;
  endproperty
  a_bad_job: assert property (p_bad_job)
    else $error("bad job ran");

  property p_idle_stop;
    @(posedge clk) disable iff (!rst_n)
      (!running && !start_req) |=> !cmd_q.start;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("start bit set");
endmodule
`default_nettype wire

/* tb/src_coil_drv_model.sv */
// Coil driver side model: step, rotation and ramp completion pulses
`timescale 1ns/1ns
`default_nettype none
module src_coil_drv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_active,
  input wire logic ramping_up,
  input wire logic ramping_down,
  input wire logic [7:0] ramp_cyc,
  output logic step_pulse,
  output logic turn_pulse,
  output logic ramp_up_done,
  output logic ramp_down_done
);
  int ph, turn_n, up_n, dn_n;
  // Pulses launched on the falling edge, one cycle wide
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {step_pulse, turn_pulse, ramp_up_done, ramp_down_done} <= 4'h0;
      {ph, turn_n, up_n, dn_n} <= '0;
    end else begin
      ph <= run_active ? (ph + 1) % 4 : 0;
      step_pulse <= run_active && ph == 3;
      turn_pulse <= run_active && ph == 3 && turn_n == 3;
      if (!run_active) begin
        turn_n <= 0;
      end else if (ph == 3) begin
        turn_n <= (turn_n + 1) % 4;
      end
      up_n <= ramping_up ? up_n + 1 : 0;
      dn_n <= ramping_down ? dn_n + 1 : 0;
      ramp_up_done <= ramping_up && up_n == int'(ramp_cyc);
      ramp_down_done <= ramping_down && dn_n == int'(ramp_cyc);
    end
  end
endmodule
`default_nettype wire

/* tb/stepper_run_controller_test.sv */
// Self-checking bench for the stepper run controller
`timescale 1ns/1ns
`default_nettype none
module stepper_run_controller_test;
  import src_pkg::*;
  logic clk, rst_n, step_pulse, turn_pulse, up_done, dn_done;
  logic irq_stop, irq_reverse, run_active, run_ccw, ramping_up;
  logic ramping_down, params_locked, ref_step_out;
  logic [1:0] coil_index, coil_last;
  logic [7:0] reg_rd_addr, reg_rd_data, ramp_cyc, rd;
  logic [7:0] mdl [3];
  logic [7:0] bc [4];
  logic [63:0] bk [4];
  src_wr_t reg_wr;
  src_counts_t counts;
  int miscompares, checked, steps, gap, k, turns;
  int seed = 32'h23d42031;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  src_run_ctrl #(.TICK_CYCLES(10)) src_run_ctrl_inst (.clk(clk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
    .counts(counts), .step_pulse(step_pulse), .turn_pulse(turn_pulse),
    .ramp_up_done(up_done), .ramp_down_done(dn_done),
    .irq_stop(irq_stop), .irq_reverse(irq_reverse),
    .reg_rd_data(reg_rd_data), .run_active(run_active),
    .run_ccw(run_ccw), .ramping_up(ramping_up),
    .ramping_down(ramping_down), .params_locked(params_locked),
    .coil_index(coil_index), .ref_step_out(ref_step_out));

  src_coil_drv_model src_coil_drv_model_inst (.clk(clk), .rst_n(rst_n),
    .run_active(run_active), .ramping_up(ramping_up),
    .ramping_down(ramping_down), .ramp_cyc(ramp_cyc),
    .step_pulse(step_pulse), .turn_pulse(turn_pulse),
    .ramp_up_done(up_done), .ramp_down_done(dn_done));

  always @(posedge clk) begin
    if (step_pulse) steps++;
    if (turn_pulse) turns++;
    if (params_locked && !run_active) gap++;
  end

  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = '{1'b1, a, d};
    @(negedge clk);
    reg_wr.wr = 1'b0;
  endtask

  // Host write that the register model follows while idle
  task automatic setp(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    mdl[a - ADDR_RAMP_SETUP] = d & (a == ADDR_REV_WAIT ? 8'hFF : 8'h3F);
  endtask

  task automatic rdchk(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= ADDR_RAMP_SETUP && a <= ADDR_CMD) ?
      mdl[a - ADDR_RAMP_SETUP] : 8'h00;
    @(negedge clk);
    reg_rd_addr = a;
    @(negedge clk);
    rd = reg_rd_data;
    check("register read", rd, e);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return params_locked;
      1: return ramping_down;
      2: return ramping_up;
      default: return run_ccw;
    endcase
  endfunction

  task automatic wait_on(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("state wait", sig(w), v);
  endtask

  task automatic run(input logic [7:0] cmd);
    steps = 0;
    turns = 0;
    gap = 0;
    setp(ADDR_CMD, cmd);
    wait_on(0, 1'b1, 4);
  endtask

  task automatic finish_run(input int lim);
    wait_on(0, 1'b0, lim);
    rdchk(ADDR_CMD);
  endtask

  initial begin
    rst_n = 1'b0;
    reg_wr = '0;
    reg_rd_addr = 8'h00;
    counts = '0;
    {irq_stop, irq_reverse} = 2'b00;
    ramp_cyc = 8'h04;
    mdl = '{8'h00, 8'h00, 8'h00};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rdchk(ADDR_RAMP_SETUP + 8'(i));
    setp(ADDR_RAMP_SETUP, 8'($random(seed)));
    setp(ADDR_REV_WAIT, 8'($random(seed)));
    setp(ADDR_CMD, 8'($random(seed)) & 8'h7F);
    for (int i = 0; i < 3; i++) rdchk(ADDR_RAMP_SETUP + 8'(i));
    setp(ADDR_RAMP_SETUP, 8'h00);
    setp(ADDR_REV_WAIT, 8'h00);
    $display("test registers done");
    bc = '{8'h80, 8'h84, 8'h8A, 8'h82};
    bk = '{64'h0000_0005_0000_0000, 64'h0005_0000_0000_0000,
      64'h0003_0000_0000_0000, 64'h0003_0005_0000_0005};
    for (int i = 0; i < 4; i++) begin
      counts = bk[i];
      setp(ADDR_CMD, bc[i]);
      repeat (3) @(negedge clk);
      check("refused start", params_locked, 1'b0);
      rdchk(ADDR_CMD);
    end
    $display("test refusal done");
    k = 2 + ($unsigned($random(seed)) % 3);
    counts = '0;
    counts.cw_steps = k[15:0];
    run(8'h80);
    check("first coil", coil_index, COIL_CW_FIRST);
    check("reference step", ref_step_out, 1'b1);
    check("moving", run_active, 1'b1);
    wr(ADDR_REV_WAIT, 8'h55);
    wr(ADDR_CMD, 8'h9F);
    finish_run(200);
    check("step total", steps, k + 1);
    rdchk(ADDR_REV_WAIT);
    coil_last = coil_index;
    counts = '0;
    counts.ccw_steps = 16'h0003;
    run(8'h81);
    check("resume coil", coil_index, coil_last);
    check("direction", run_ccw, 1'b1);
    finish_run(200);
    check("step total", steps, 3);
    counts = '0;
    counts.cw_turns = 16'h0002;
    run(8'h84);
    finish_run(200);
    check("turn total", turns, 2);
    check("step total", steps, 8);
    counts.cw_steps = 16'h0002;
    counts.cw_turns = 16'h0001;
    run(8'h88);
    finish_run(200);
    check("turn total", turns, 1);
    check("step total", steps, 4);
    $display("test single runs done");
    ramp_cyc = 8'h3C;
    counts = '0;
    counts.cw_steps = 16'h0032;
    for (int i = 0; i < 3; i++) begin
      setp(ADDR_RAMP_SETUP, i == 2 ? 8'h20 : 8'h30);
      run(i == 0 ? 8'hA0 : 8'h80);
      repeat (3) @(negedge clk);
      check("ramping up", ramping_up, 1'b1);
      wr(ADDR_CMD, 8'h00);
      @(negedge clk);
      check("stop in ramp up", ramping_down, i == 1);
      check("run held", params_locked, i == 1);
      finish_run(200);
    end
    setp(ADDR_RAMP_SETUP, 8'h10);
    for (int i = 0; i < 2; i++) begin
      run(i == 0 ? 8'hA0 : 8'h80);
      @(negedge clk) irq_stop = 1'b1;
      @(negedge clk) irq_stop = 1'b0;
      wait_on(1, 1'b1, 4);
      wr(ADDR_CMD, 8'h00);
      @(negedge clk);
      check("stop in ramp down", ramping_down, i == 1);
      finish_run(200);
    end
    $display("test host stops done");
    ramp_cyc = 8'h1E;
    setp(ADDR_RAMP_SETUP, 8'h30);
    counts.cw_steps = 16'h00C8;
    run(8'hB0);
    wait_on(2, 1'b1, 4);
    @(negedge clk) irq_stop = 1'b1;
    @(negedge clk) irq_stop = 1'b0;
    repeat (3) @(negedge clk);
    check("ramp not cut", ramping_up, 1'b1);
    wait_on(1, 1'b1, 60);
    finish_run(200);
    $display("test latched interrupt done");
    ramp_cyc = 8'h04;
    setp(ADDR_RAMP_SETUP, 8'h00);
    counts = '0;
    counts.cw_steps = 16'h0002;
    counts.ccw_steps = 16'h0002;
    for (int w = 0; w < 3; w += 2) begin
      setp(ADDR_REV_WAIT, 8'(w));
      run(w == 0 ? 8'h82 : 8'h83);
      wait_on(3, w == 0, 400);
      finish_run(200);
      check("reversal gap", (gap - w * 10) inside {[0:8]}, 1);
      check("step total", steps, 4);
    end
    setp(ADDR_REV_WAIT, 8'h00);
    counts.cw_steps = 16'h0001;
    counts.ccw_steps = 16'h0001;
    run(8'h92);
    repeat (150) @(negedge clk);
    check("still running", params_locked, 1'b1);
    check("legs repeat", steps >= 6, 1);
    wr(ADDR_CMD, 8'h00);
    finish_run(10);
    run(8'h90);
    @(negedge clk) irq_reverse = 1'b1;
    @(negedge clk) irq_reverse = 1'b0;
    wait_on(3, 1'b1, 20);
    wr(ADDR_CMD, 8'h00);
    finish_run(10);
    wr(ADDR_CMD, 8'h12);
    repeat (3) @(negedge clk);
    check("stop when idle", params_locked, 1'b0);
    $display("test continuous done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    mdl = '{8'h00, 8'h00, 8'h00};
    rdchk(ADDR_CMD);
    counts.ccw_steps = 16'h0003;
    run(8'h81);
    check("first coil", coil_index, COIL_CCW_FIRST);
    check("reference step", ref_step_out, 1'b1);
    finish_run(200);
    check("step total", steps, 4);
    $display("test reset done");
    wrap_up();
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
